// ### pmfs_pkg.sv
// Purpose: constants for the pfc mode and fault supervisor
// Assumes: adc codes are unsigned, full scale tied to the reference current
// Notes: thresholds are ratios of the reference code

package pmfs_pkg;
  localparam int ADC_W = 12;
  localparam int CLK_HZ = 125_000_000;
  // reference current code at nominal link voltage (129 uA)
  localparam int REF_UA = 129;
  localparam logic [11:0] REF_CODE = 12'h0_C00;
  localparam int STARTUP_ENTER_PCT = 90;
  localparam int STARTUP_EXIT_PCT = 100;
  localparam int OVP_TRIP_PCT = 105;
  localparam int BURST_PWR_PCT = 5;
  localparam int MAX_SWITCH_FREQUENCY_KHZ = 70;
  localparam int PERIOD_MIN_CYC = (CLK_HZ + MAX_SWITCH_FREQUENCY_KHZ * 1000 - 1) / (MAX_SWITCH_FREQUENCY_KHZ * 1000);
  localparam int BO_TIME_MS = 56;
  localparam int BO_CYC = CLK_HZ / 1000 * BO_TIME_MS;
  localparam int PEAK_DECAY_V = 5;
  localparam int LOOP_RESP_US = 150;
  localparam int LOOP_RESP_CYC = CLK_HZ / 1_000_000 * LOOP_RESP_US;
  localparam int SLEW_V_PER_US = 2;
  localparam int SAMPLE_NS = 1000;
  localparam int SAMPLE_CYC = CLK_HZ / 1_000_000_000 * SAMPLE_NS + SAMPLE_NS / 8;
  typedef enum logic [1:0] {PMFS_STARTUP, PMFS_NORMAL, PMFS_BURST, PMFS_STANDBY} pmfs_mode_t;
endpackage

// ### pmfs_qual_timer.sv
// Purpose: qualification timer, fires when a condition holds long enough
// Assumes: cond_i is synchronous
// Notes: count restarts whenever the condition drops

`timescale 1ns/100ps
module pmfs_qual_timer #(
  parameter int LIMIT = 7_000_000
) (
  input wire logic clock_i,   // system clock
  input wire logic resetn_i,  // async reset, low
  input wire logic cond_i,    // condition to qualify
  output logic done_o         // held long enough
);
  logic [31:0] cnt_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= 32'h0000_0000;
      done_o <= 1'b0;
    end else if (!cond_i) begin
      cnt_q <= 32'h0000_0000;
      done_o <= 1'b0;
    end else if (cnt_q >= 32'(LIMIT)) begin
      done_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end
endmodule

// ### pmfs_sample_sync.sv
// Purpose: three-stage synchroniser for one adc word with its strobe
// Assumes: word is stable while the strobe toggles
// Notes: word captured when stages two and three agree on a toggle

`timescale 1ns/100ps
module pmfs_sample_sync #(
  parameter int W = 12
) (
  input wire logic clock_i,      // system clock
  input wire logic resetn_i,     // async reset, low
  input wire logic tog_i,        // sample toggle from adc
  input wire logic [W-1:0] d_i,  // sample word
  output logic [W-1:0] q_o,      // captured sample
  output logic stb_o             // new sample pulse
);
  logic [2:0] s_q;
  logic last_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= 3'h0;
      last_q <= 1'b0;
      q_o <= '0;
      stb_o <= 1'b0;
    end else begin
      s_q <= {s_q[1:0], tog_i};
      stb_o <= 1'b0;
      if (s_q[1] == s_q[2] && s_q[2] != last_q) begin
        last_q <= s_q[2];
        q_o <= d_i;
        stb_o <= 1'b1;
      end
    end
  end
endmodule

// ### pmfs_stage_model.sv
// Purpose: power stage seen through its sense converters
// Assumes: bench sets the levels to report
// Notes: word moves two cycles before its toggle
`timescale 1ns/100ps
module pmfs_stage_model (
  input wire logic clock_i,          // clock
  input wire logic resetn_i,         // reset, low
  input wire logic slow_i,           // doubles the sample period
  input wire logic [11:0] fb_code_i, // link level
  input wire logic [11:0] ac_code_i, // line level
  output logic fb_tog_o,             // fb toggle
  output logic [11:0] fb_o,          // fb word
  output logic ac_tog_o,             // ac toggle
  output logic [11:0] ac_o           // ac word
);
  logic [3:0] cnt_q;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) cnt_q <= 4'h0;
    else cnt_q <= (cnt_q == (slow_i ? 4'hF : 4'h7)) ? 4'h0 : cnt_q + 4'h1;
  end
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fb_o <= 12'h0_000;
      ac_o <= 12'h0_000;
    end else if (cnt_q == 4'h0) begin
      fb_o <= fb_code_i;
      ac_o <= ac_code_i;
    end
  end
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fb_tog_o <= 1'b0;
      ac_tog_o <= 1'b0;
    end else if (cnt_q == 4'h2) begin
      fb_tog_o <= ~fb_tog_o;
      ac_tog_o <= ~ac_tog_o;
    end
  end
endmodule

// ### pmfs_supervisor.sv
// Purpose: mode and protection supervisor of a pfc controller
// Assumes: adc words come from another domain with a toggle strobe each
// Notes: codes are ratios of the reference code, control law kept simple

`timescale 1ns/100ps
module pmfs_supervisor #(
  parameter int ADC_W = pmfs_pkg::ADC_W,
  parameter int BO_CYC = pmfs_pkg::BO_CYC,
  parameter logic [11:0] BO_LOW_CODE = 12'h0_300,   // lower brownout level
  parameter logic [11:0] BO_HIGH_CODE = 12'h0_380,  // upper brownout level
  parameter logic [11:0] OVP_HYST_CODE = 12'h0_01A, // overvoltage hysteresis
  parameter logic [11:0] DECAY_CODE = 12'h0_008,    // 5 V step in code
  parameter logic [15:0] HALF_LINE_CYC = 16'hF424   // half-line time in cycles
) (
  input wire logic clock_i,                    // 125 MHz clock
  input wire logic resetn_i,                   // async reset, low
  input wire logic fb_tog_i,                   // output sense sample toggle
  input wire logic [ADC_W-1:0] output_sense_current_input_i, // output sense code
  input wire logic ac_tog_i,                   // line sense sample toggle
  input wire logic [ADC_W-1:0] line_sense_current_input_i,   // line sense code
  output logic gate_o,                         // gate drive
  output logic [1:0] mode_o,                   // operating mode
  output logic brownout_o,                     // brownout active
  output logic ovp_o,                          // overvoltage stop active
  output logic loop_fault_o                    // loop fault active
);
  // ==========================================================
  // sample capture
  logic [ADC_W-1:0] fb_s, ac_s;
  logic fb_stb, ac_stb;

  pmfs_sample_sync #(.W(ADC_W)) u_fb (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .tog_i(fb_tog_i),
    .d_i(output_sense_current_input_i),
    .q_o(fb_s),
    .stb_o(fb_stb)
  );

  pmfs_sample_sync #(.W(ADC_W)) u_ac (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .tog_i(ac_tog_i),
    .d_i(line_sense_current_input_i),
    .q_o(ac_s),
    .stb_o(ac_stb)
  );

  // ==========================================================
  // measured output, slew limited when falling, follows a rise at once
  logic [ADC_W-1:0] vout_q;
  localparam logic [11:0] SLEW_STEP = 12'h0_004;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vout_q <= '0;
    end else if (fb_stb) begin
      // widened so a code near full scale cannot wrap the compare
      if ({1'b0, fb_s} + {1'b0, SLEW_STEP} < {1'b0, vout_q}) begin
        vout_q <= vout_q - SLEW_STEP;
      end else begin
        vout_q <= fb_s;
      end
    end
  end

  // ==========================================================
  // line peak hold with limited decay
  // held peak follows a new maximum at once unless its strobe lands on a half-line end, falls only at half-line ends
  logic [ADC_W-1:0] peak_q, hmax_q;
  logic [15:0] half_q;
  logic half_end;
  assign half_end = (half_q >= HALF_LINE_CYC);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      half_q <= 16'h0000;
    end else if (half_end) begin
      half_q <= 16'h0000;
    end else begin
      half_q <= half_q + 16'h0001;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hmax_q <= '0;
      peak_q <= '0;
    end else if (half_end) begin
      hmax_q <= '0;
      if (hmax_q >= peak_q) begin
        peak_q <= hmax_q;
      end else if (peak_q - hmax_q > DECAY_CODE) begin
        peak_q <= peak_q - DECAY_CODE;
      end else begin
        peak_q <= hmax_q;
      end
    end else if (ac_stb && ac_s > hmax_q) begin
      hmax_q <= ac_s;
      if (ac_s > peak_q) begin
        peak_q <= ac_s;
      end
    end
  end

  // ==========================================================
  // brownout qualification
  // entry timer restarts whenever the held peak climbs back over the level
  logic bo_enter, bo_exit;

  pmfs_qual_timer #(.LIMIT(BO_CYC)) u_bo_lo (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .cond_i(!brownout_o && peak_q < BO_LOW_CODE),
    .done_o(bo_enter)
  );

  pmfs_qual_timer #(.LIMIT(BO_CYC)) u_bo_hi (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .cond_i(brownout_o && peak_q > BO_HIGH_CODE),
    .done_o(bo_exit)
  );

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      brownout_o <= 1'b0;
    end else if (bo_enter) begin
      brownout_o <= 1'b1;
    end else if (bo_exit) begin
      brownout_o <= 1'b0;
    end
  end

  // ==========================================================
  // overvoltage and loop protection
  // thresholds worked at full integer width, a 14-bit product would wrap
  localparam logic [13:0] TRIP14 =
    14'(pmfs_pkg::REF_CODE * pmfs_pkg::OVP_TRIP_PCT / 100);
  localparam logic [13:0] LO14 =
    14'(pmfs_pkg::REF_CODE * pmfs_pkg::STARTUP_ENTER_PCT / 100);
  localparam logic [13:0] HI14 =
    14'(pmfs_pkg::REF_CODE * pmfs_pkg::STARTUP_EXIT_PCT / 100);
  // light-load bound: reference share over sixteen, scaled by the power percent
  localparam logic [19:0] LIGHT20 =
    20'(pmfs_pkg::REF_CODE * pmfs_pkg::BURST_PWR_PCT / 16);
  // set terms tested first, so a trip and a clear together leave the flag set
  logic [13:0] ovp_trip;
  assign ovp_trip = TRIP14;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovp_o <= 1'b0;
    end else if ({2'b00, fb_s} > ovp_trip) begin
      ovp_o <= 1'b1;
    end else if ({2'b00, fb_s} + {2'b00, OVP_HYST_CODE} < ovp_trip) begin
      ovp_o <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      loop_fault_o <= 1'b0;
    end else if (vout_q < ac_s) begin
      loop_fault_o <= 1'b1;
    end else if (fb_s >= ac_s && vout_q > peak_q) begin
      loop_fault_o <= 1'b0;
    end
  end

  // ==========================================================
  // mode selection
  pmfs_pkg::pmfs_mode_t mode_q;
  logic [13:0] v14, lo90, hi100;
  assign v14 = {2'b00, vout_q};
  assign lo90 = LO14;
  assign hi100 = HI14;

  // power estimate: error below reference scaled, light load only at zero error, output at or over reference
  logic [ADC_W-1:0] err;
  logic light;
  assign err = (pmfs_pkg::REF_CODE > vout_q) ? pmfs_pkg::REF_CODE - vout_q : '0;
  assign light = ({8'h00, err} * 20'd100 < LIGHT20)
    && vout_q >= pmfs_pkg::REF_CODE;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_q <= pmfs_pkg::PMFS_STARTUP;
    end else begin
      case (mode_q)
        pmfs_pkg::PMFS_STARTUP: begin
          if (brownout_o) begin
            mode_q <= pmfs_pkg::PMFS_STANDBY;
          end else if (v14 >= hi100) begin
            mode_q <= pmfs_pkg::PMFS_NORMAL;
          end
        end
        pmfs_pkg::PMFS_NORMAL, pmfs_pkg::PMFS_BURST: begin
          if (brownout_o) begin
            mode_q <= pmfs_pkg::PMFS_STANDBY;
          end else if (v14 < lo90) begin
            mode_q <= pmfs_pkg::PMFS_STARTUP;
          end else if (half_end) begin
            mode_q <= light ? pmfs_pkg::PMFS_BURST : pmfs_pkg::PMFS_NORMAL;
          end
        end
        default: begin
          if (!brownout_o) begin
            mode_q <= pmfs_pkg::PMFS_NORMAL;
          end
        end
      endcase
    end
  end

  // burst gating per whole half-line period
  logic burst_off_q;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      burst_off_q <= 1'b0;
    end else if (mode_q != pmfs_pkg::PMFS_BURST) begin
      burst_off_q <= 1'b0;
    end else if (half_end) begin
      burst_off_q <= !burst_off_q;
    end
  end

  // ==========================================================
  // switching cycle generator
  logic [15:0] cyc_q, period, ton;
  logic [15:0] minp;
  assign minp = 16'(pmfs_pkg::PERIOD_MIN_CYC);
  // period shortest at line peak, longest near the trough
  assign period = minp + 16'({4'h0, ~ac_s} >> 2);
  // start-up: on-time fixed for constant peak current; normal: error driven
  assign ton = (mode_q == pmfs_pkg::PMFS_STARTUP) ? (minp >> 1)
    : 16'(({4'h0, err} >> 4) + 16'h0004);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cyc_q <= 16'h0000;
    end else if (cyc_q + 16'h0001 >= period) begin
      cyc_q <= 16'h0000;
    end else begin
      cyc_q <= cyc_q + 16'h0001;
    end
  end

  logic enable;
  assign enable = !brownout_o && !ovp_o && !loop_fault_o && !burst_off_q
    && mode_q != pmfs_pkg::PMFS_STANDBY;

  // a pulse only starts at the head of a switching cycle; a pulse cut by a
  // fault is not restarted later in the same cycle, so the rate limit holds
  logic pulse_start, pulse_keep;
  assign pulse_start = (cyc_q == 16'h0000);
  assign pulse_keep = gate_o && (cyc_q < ton);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gate_o <= 1'b0;
    end else if (!enable) begin
      gate_o <= 1'b0;
    end else if (cyc_q >= period - 16'h0001) begin
      gate_o <= 1'b0;
    end else begin
      gate_o <= pulse_start || pulse_keep;
    end
  end

  // ==========================================================
  // mode report, one cycle behind the mode register
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_o <= 2'h0;
    end else begin
      mode_o <= mode_q;
    end
  end
endmodule

// ### pmfs_supervisor_props.sv
// Purpose: port assertions for the pfc supervisor
// Assumes: sample words hold steady around each toggle
// Notes: attached by the bind at the foot
`timescale 1ns/100ps
module pmfs_supervisor_chk #(
  parameter int ADC_W = 12,
  parameter int BO_CYC = 50,
  parameter logic [11:0] BO_LOW_CODE = 12'h0_300,
  parameter logic [11:0] OVP_HYST_CODE = 12'h0_01A
) (
  input wire logic clock_i,  // clock
  input wire logic resetn_i, // reset, low
  input wire logic fb_tog_i, // fb toggle
  input wire logic [ADC_W-1:0] output_sense_current_input_i, // fb word
  input wire logic ac_tog_i, // ac toggle
  input wire logic [ADC_W-1:0] line_sense_current_input_i, // ac word
  input wire logic gate_o, // gate
  input wire logic [1:0] mode_o, // mode
  input wire logic brownout_o, // brownout
  input wire logic ovp_o, // overvoltage
  input wire logic loop_fault_o // loop fault
);
  localparam logic [12:0] TRIP = 13'(pmfs_pkg::REF_CODE * pmfs_pkg::OVP_TRIP_PCT / 100);
  localparam logic [11:0] LOW90 = 12'(pmfs_pkg::REF_CODE * pmfs_pkg::STARTUP_ENTER_PCT / 100);
  logic fb_t_q, ac_t_q, g_q;
  logic [ADC_W-1:0] fb_q, ac_q;
  int low_q, bo_q, gap_q;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // ==========
  // last words and run lengths
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fb_t_q <= 1'b0;
      ac_t_q <= 1'b0;
      fb_q <= '0;
      ac_q <= '0;
    end else begin
      fb_t_q <= fb_tog_i;
      ac_t_q <= ac_tog_i;
      if (fb_tog_i != fb_t_q) fb_q <= output_sense_current_input_i;
      if (ac_tog_i != ac_t_q) ac_q <= line_sense_current_input_i;
    end
  end
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_q <= 0;
      bo_q <= 0;
    end else begin
      low_q <= (ac_q < BO_LOW_CODE) ? low_q + 1 : 0;
      bo_q <= brownout_o ? bo_q + 1 : 0;
    end
  end
  // cycles since the last gate rise, seeded so the first rise passes
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      g_q <= 1'b0;
      gap_q <= pmfs_pkg::PERIOD_MIN_CYC;
    end else begin
      g_q <= gate_o;
      gap_q <= (gate_o && !g_q) ? 1 : gap_q + 1;
    end
  end
  // ==========
  // properties
  property p_gate_and;
    (brownout_o || ovp_o || loop_fault_o) |=> !gate_o;
  endproperty
  a_gate_and: assert property (p_gate_and) else $error("gate on in fault");
  property p_ovp_set;
    (fb_tog_i != fb_t_q) && (13'(output_sense_current_input_i) > TRIP)
      |-> ##[2:8] ovp_o ##1 !gate_o;
  endproperty
  a_ovp_set: assert property (p_ovp_set) else $error("overvoltage missed");
  property p_ovp_clear;
    $fell(ovp_o) |-> (13'(fb_q) + 13'(OVP_HYST_CODE) < TRIP);
  endproperty
  a_ovp_clear: assert property (p_ovp_clear) else $error("overvoltage cleared early");
  property p_loop_clear;
    $fell(loop_fault_o) |-> (fb_q >= ac_q);
  endproperty
  a_loop_clear: assert property (p_loop_clear) else $error("loop fault cleared early");
  property p_bo_enter;
    $rose(brownout_o) |-> (low_q + 2 >= BO_CYC);
  endproperty
  a_bo_enter: assert property (p_bo_enter) else $error("brownout too soon");
  property p_bo_exit;
    $fell(brownout_o) |-> (bo_q + 2 >= BO_CYC);
  endproperty
  a_bo_exit: assert property (p_bo_exit) else $error("brownout left too soon");
  property p_bo_standby;
    $rose(brownout_o) |-> ##[0:2] (mode_o == 2'h3);
  endproperty
  a_bo_standby: assert property (p_bo_standby) else $error("no standby");
  property p_startup;
    ($past(mode_o) == 2'h1) && (mode_o == 2'h0) |-> (fb_q <= LOW90);
  endproperty
  a_startup: assert property (p_startup) else $error("start-up entered high");
  property p_gate_rate;
    (gate_o && !g_q) |-> (gap_q >= pmfs_pkg::PERIOD_MIN_CYC);
  endproperty
  a_gate_rate: assert property (p_gate_rate) else $error("gate pulses too close");
endmodule

bind pmfs_supervisor pmfs_supervisor_chk #(.ADC_W(ADC_W), .BO_CYC(BO_CYC),
  .BO_LOW_CODE(BO_LOW_CODE), .OVP_HYST_CODE(OVP_HYST_CODE)) i_chk (
  .clock_i(clock_i), .resetn_i(resetn_i), .fb_tog_i(fb_tog_i), .ac_tog_i(ac_tog_i),
  .output_sense_current_input_i(output_sense_current_input_i),
  .line_sense_current_input_i(line_sense_current_input_i), .gate_o(gate_o),
  .mode_o(mode_o), .brownout_o(brownout_o), .ovp_o(ovp_o), .loop_fault_o(loop_fault_o));

// ### pmfs_supervisor_tb.sv
// Purpose: self-checking bench for the pfc supervisor
// Assumes: stage model feeds both sample words
// Notes: brownout and half-line counts shortened
`timescale 1ns/100ps
module pmfs_supervisor_tb;
  localparam int BO = 50;
  localparam logic [11:0] REF = pmfs_pkg::REF_CODE;
  localparam logic [11:0] TRIP = 12'(REF * pmfs_pkg::OVP_TRIP_PCT / 100);
  logic clock_i, resetn_i, slow, fb_tog, ac_tog, gate_o, bo_o, ovp_o, lf_o, ovp_x;
  logic [11:0] fb_c, ac_c, fb_w, ac_w, f;
  logic [1:0] mode_o;
  logic [11:0] corner [4] = '{12'h0_C99, 12'h0_C9A, 12'h0_C7F, 12'h0_C7E};
  int fail_count, check_count, n;
  pmfs_stage_model i_stage (.clock_i(clock_i), .resetn_i(resetn_i), .slow_i(slow),
    .fb_code_i(fb_c), .ac_code_i(ac_c), .fb_tog_o(fb_tog), .fb_o(fb_w),
    .ac_tog_o(ac_tog), .ac_o(ac_w));
  pmfs_supervisor #(.BO_CYC(BO), .HALF_LINE_CYC(16'h0_040)) i_dut (.clock_i(clock_i),
    .resetn_i(resetn_i), .fb_tog_i(fb_tog), .output_sense_current_input_i(fb_w),
    .ac_tog_i(ac_tog), .line_sense_current_input_i(ac_w), .gate_o(gate_o),
    .mode_o(mode_o), .brownout_o(bo_o), .ovp_o(ovp_o), .loop_fault_o(lf_o));
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // ==========
  // helpers
  function automatic logic ovp_next(input logic [11:0] v, input logic p);
    return (v > TRIP) || (p && (13'(v) + 13'h0_01A >= 13'(TRIP)));
  endfunction
  function automatic logic [11:0] pick(input int w);
    case (w)
      0: return {10'h0, mode_o};
      1: return {11'h0, gate_o};
      2: return {11'h0, bo_o};
      3: return {11'h0, ovp_o};
      default: return {11'h0, lf_o};
    endcase
  endfunction
  task automatic results;
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic drive(input logic [11:0] v, input logic [11:0] a, input logic s, input int c);
    @(posedge clock_i);
    fb_c <= v;
    ac_c <= a;
    slow <= s;
    repeat (c) @(negedge clock_i);
  endtask
  task automatic wait_for(input int w, input logic [11:0] v, input logic ne, input int b);
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (((pick(w) === v) == ne) && n < b);
    if ((pick(w) === v) == ne) begin
      fail_count++;
      $display("wrong value at %0t: timeout", $time);
      results();
    end
  endtask
  // ==========
  // main sequence
  initial begin
    fail_count = 0;
    check_count = 0;
    fb_c = 12'h0_000;
    ac_c = 12'h0_000;
    slow = 1'b0;
    resetn_i = 1'b0;
    n = $urandom(90607);
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(negedge clock_i);
    check(pick(0), 12'h0_000, "start mode");
    check(pick(1), 12'h0_000, "gate after reset");
    drive(REF, 12'h0_500, 1'b0, 0);
    wait_for(0, 12'h0_000, 1'b1, 4000);
    ovp_x = 1'b0;
    for (int k = 0; k < 16; k++) begin
      f = (k < 4) ? corner[k] : REF + 12'($urandom_range(0, 288));
      drive(f, 12'($urandom_range(912, 2816)), k[0], 40);
      ovp_x = ovp_next(f, ovp_x);
      check(pick(3), {11'h0, ovp_x}, "overvoltage flag");
      if (ovp_x) check(pick(1), 12'h0_000, "gate in overvoltage");
    end
    drive(12'h0_A00, 12'h0_500, 1'b0, 0);
    wait_for(0, 12'h0_000, 1'b0, 4000);
    drive(12'h0_BFF, 12'h0_500, 1'b0, 40);
    check(pick(0), 12'h0_000, "start-up left early");
    drive(REF, 12'h0_500, 1'b0, 0);
    wait_for(0, 12'h0_000, 1'b1, 400);
    drive(12'h0_100, 12'h0_500, 1'b0, 0);
    wait_for(4, 12'h0_001, 1'b0, 6000);
    check(12'(n >= 3500), 12'h0_001, "output measure fell too fast");
    repeat (2) @(negedge clock_i);
    check(pick(1), 12'h0_000, "gate in loop fault");
    drive(12'h0_4FF, 12'h0_500, 1'b0, 40);
    check(pick(4), 12'h0_001, "loop fault cleared early");
    drive(REF, 12'h0_500, 1'b0, 0);
    wait_for(4, 12'h0_000, 1'b0, 400);
    wait_for(0, 12'h0_002, 1'b0, 400);
    wait_for(1, 12'h0_001, 1'b0, 20000);
    drive(REF, 12'h0_200, 1'b0, 0);
    wait_for(2, 12'h0_001, 1'b0, 20000);
    repeat (4) @(negedge clock_i);
    check(pick(0), 12'h0_003, "no standby");
    check(pick(1), 12'h0_000, "gate in brownout");
    drive(REF, 12'h0_400, 1'b0, 0);
    wait_for(2, 12'h0_000, 1'b0, 2000);
    check(12'(n >= BO), 12'h0_001, "brownout left early");
    wait_for(0, 12'h0_003, 1'b1, 100);
    check(pick(0), 12'h0_001, "not normal after brownout");
    @(posedge clock_i);
    resetn_i <= 1'b0;
    repeat (2) @(negedge clock_i);
    check({9'h0, mode_o, gate_o}, 12'h0_000, "state in reset");
    results();
  end
endmodule
